// [hdl/lcd_pkg.sv]
// constants, field layout and types of the channel divider block
// shared by the register file, the sub-dividers and their carrier interface
package lcd_pkg;

    localparam int        DATA_W          = 32;
    localparam int        ADDR_W          = 12;
    localparam int        CNT_W           = 4;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_DIV2_FIRST  = 10'h199;
    localparam logic [9:0] IDX_DIV2_PHASE  = 10'h19a;
    localparam logic [9:0] IDX_DIV2_SECOND = 10'h19b;
    localparam logic [9:0] IDX_DIV2_CTRL   = 10'h19c;
    localparam logic [9:0] IDX_DIV2_DCC    = 10'h19d;
    localparam logic [9:0] IDX_DIV3_FIRST  = 10'h19e;
    localparam logic [9:0] IDX_STATUS      = 10'h1f0;

    // field positions
    localparam int        F_LOW_LSB       = 4;
    localparam int        F_HIGH_LSB      = 0;
    localparam int        F_PH22_LSB      = 4;
    localparam int        F_PH21_LSB      = 0;
    localparam int        F_BYP22         = 5;
    localparam int        F_BYP21         = 4;
    localparam int        F_NOSYNC        = 3;
    localparam int        F_FORCE         = 2;
    localparam int        F_START22       = 1;
    localparam int        F_START21       = 0;
    localparam int        F_DCC_OFF       = 0;

    // reset values
    localparam logic [7:0] RST_COUNTS      = 8'h00;
    localparam logic [7:0] RST_PHASE       = 8'h00;
    localparam logic [7:0] RST_CTRL        = 8'h00;
    localparam logic [7:0] RST_DCC         = 8'h00;

    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    typedef enum logic [2:0] {
        ST_OFF  = 3'h1,
        ST_WAIT = 3'h2,
        ST_RUN  = 3'h4
    } lcd_div_state_t;

    // byte address to register index; hit is low for unaligned or unmapped
    function automatic logic [10:0] lcd_decode(input logic [ADDR_W-1:0] addr);
        logic [9:0] idx;
        logic       hit;
        idx = addr[ADDR_W-1:2];
        hit = (addr[1:0] == 2'h0) &&
              ((idx >= IDX_DIV2_FIRST && idx <= IDX_DIV3_FIRST) || idx == IDX_STATUS);
        return {hit, idx};
    endfunction : lcd_decode

endpackage : lcd_pkg

// [hdl/lcd_div_if.sv]
// carrier between the register block and one sub-divider
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface lcd_div_if;
    import lcd_pkg::*;
    logic             in_tick;
    logic             in_lvl;
    logic             restart;
    logic             bypass;
    logic             start_hi;
    logic [CNT_W-1:0] phase;
    logic [CNT_W-1:0] low_n;
    logic [CNT_W-1:0] high_n;
    logic             out;
    logic             running;

    modport ctl (output in_tick, in_lvl, restart, bypass, start_hi, phase, low_n, high_n,
                 input out, running);
    modport div (input in_tick, in_lvl, restart, bypass, start_hi, phase, low_n, high_n,
                 output out, running);
endinterface : lcd_div_if

// [hdl/lcd_subdiv.sv]
// one programmable sub-divider: low/high counts, phase wait, start level, bypass
// assumes in_tick marks each rising edge of its input clock, in_lvl that clock's level
`timescale 1ns/1ps
module lcd_subdiv
    import lcd_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    lcd_div_if.div    dif
);
    lcd_div_state_t   st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] ph_q, ph_d;
    logic             lvl_q, lvl_d;
    logic             out_q, out_d;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        ph_d  = ph_q;
        lvl_d = lvl_q;
        if (dif.bypass) begin
            // counting logic held idle while bypassed
            st_d  = ST_OFF;
            cnt_d = '0;
            lvl_d = dif.start_hi;
        end else if (dif.restart || st_q == ST_OFF) begin
            st_d  = ST_WAIT;
            ph_d  = dif.phase;
            cnt_d = '0;
            lvl_d = dif.start_hi;
        end else begin
            case (st_q)
                ST_WAIT: begin
                    if (ph_q == '0) begin
                        st_d = ST_RUN;
                    end else if (dif.in_tick) begin
                        ph_d = ph_q - 1'b1;
                    end
                end
                ST_RUN: begin
                    if (dif.in_tick) begin
                        if (cnt_q == (lvl_q ? dif.high_n : dif.low_n)) begin
                            lvl_d = ~lvl_q;
                            cnt_d = '0;
                        end else begin
                            cnt_d = cnt_q + 1'b1;
                        end
                    end
                end
                default: st_d = ST_OFF;
            endcase
        end
        out_d = dif.bypass ? dif.in_lvl : lvl_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q  <= ST_OFF;
            cnt_q <= '0;
            ph_q  <= '0;
            lvl_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            ph_q  <= ph_d;
            lvl_q <= lvl_d;
            out_q <= out_d;
        end
    end

    assign dif.out     = out_q;
    assign dif.running = (st_q == ST_RUN);

    sequence s_restart_done;
        dif.restart ##1 !dif.restart;
    endsequence

    a_low_ends_high: assert property (@(posedge clk) disable iff (rst)
        (st_q == ST_RUN && !dif.bypass && !dif.restart && dif.in_tick && !lvl_q
         && cnt_q == dif.low_n) |=> lvl_q)
        else $error("low phase did not end after low count plus one ticks");
    a_high_ends_low: assert property (@(posedge clk) disable iff (rst)
        (st_q == ST_RUN && !dif.bypass && !dif.restart && dif.in_tick && lvl_q
         && cnt_q == dif.high_n) |=> !lvl_q)
        else $error("high phase did not end after high count plus one ticks");
    a_low_holds: assert property (@(posedge clk) disable iff (rst)
        (st_q == ST_RUN && !dif.bypass && !dif.restart && !lvl_q
         && cnt_q < dif.low_n) |=> !lvl_q)
        else $error("low phase ended early");
    a_start_level: assert property (@(posedge clk) disable iff (rst)
        (dif.restart && !dif.bypass) |=> (lvl_q == $past(dif.start_hi) && st_q == ST_WAIT))
        else $error("restart did not load start level");
    a_phase_hold: assert property (@(posedge clk) disable iff (rst)
        s_restart_done ##0 (ph_q != '0 && !dif.bypass) |=> $stable(lvl_q) && st_q == ST_WAIT)
        else $error("output moved during phase wait");
    a_bypass_pass: assert property (@(posedge clk) disable iff (rst)
        dif.bypass |=> (out_q == $past(dif.in_lvl) && st_q == ST_OFF))
        else $error("bypass did not route the input clock");

endmodule : lcd_subdiv

// [hdl/lcd_channel_divider.sv]
// channel 2 divider pair plus channel 3 first stage, with an AXI4-Lite register slave
// assumes div_in and sync_in are synchronous to clk; one AXI transaction per direction
`timescale 1ns/1ps
module lcd_channel_divider
    import lcd_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              div_in,
    input  wire logic              sync_in,
    output logic                   div2_out,
    output logic                   div3_1_out,
    output logic                   duty_correction_on,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    // ---------------- AXI4-Lite write path ----------------
    logic              aw_full_q, aw_full_d;
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic              w_full_q,  w_full_d;
    logic [7:0]        w_data_q,  w_data_d;
    logic              w_lane_q,  w_lane_d;
    logic              bvalid_q,  bvalid_d;
    logic [1:0]        bresp_q,   bresp_d;
    logic              wr_go;
    logic [10:0]       wr_dec;

    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready  = !w_full_q && !bvalid_q;
    assign wr_go         = aw_full_q && w_full_q && !bvalid_q;
    assign wr_dec        = lcd_decode(aw_addr_q);

    always_comb begin
        aw_full_d = aw_full_q;
        aw_addr_d = aw_addr_q;
        w_full_d  = w_full_q;
        w_data_d  = w_data_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_d = 1'b1;
            w_data_d = s_axi_wdata[7:0];
            w_lane_d = s_axi_wstrb[0];
        end
        if (wr_go) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = wr_dec[10] ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_full_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            aw_full_q <= aw_full_d;
            aw_addr_q <= aw_addr_d;
            w_full_q  <= w_full_d;
            w_data_q  <= w_data_d;
            w_lane_q  <= w_lane_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ---------------- configuration registers ----------------
    logic [7:0] first_q,  first_d;
    logic [7:0] phase_q,  phase_d;
    logic [7:0] second_q, second_d;
    logic [5:0] ctrl_q,   ctrl_d;
    logic       dcc_q,    dcc_d;
    logic [7:0] div3_q,   div3_d;
    logic       reg_we;

    // only byte lane 0 carries register data
    assign reg_we = wr_go && wr_dec[10] && w_lane_q;

    always_comb begin
        first_d  = first_q;
        phase_d  = phase_q;
        second_d = second_q;
        ctrl_d   = ctrl_q;
        dcc_d    = dcc_q;
        div3_d   = div3_q;
        if (reg_we) begin
            case (wr_dec[9:0])
                IDX_DIV2_FIRST:  first_d  = w_data_q;
                IDX_DIV2_PHASE:  phase_d  = w_data_q;
                IDX_DIV2_SECOND: second_d = w_data_q;
                IDX_DIV2_CTRL:   ctrl_d   = w_data_q[5:0];
                IDX_DIV2_DCC:    dcc_d    = w_data_q[F_DCC_OFF];
                IDX_DIV3_FIRST:  div3_d   = w_data_q;
                default:         ctrl_d   = ctrl_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            first_q  <= RST_COUNTS;
            phase_q  <= RST_PHASE;
            second_q <= RST_COUNTS;
            ctrl_q   <= RST_CTRL[5:0];
            dcc_q    <= RST_DCC[F_DCC_OFF];
            div3_q   <= RST_COUNTS;
        end else begin
            first_q  <= first_d;
            phase_q  <= phase_d;
            second_q <= second_d;
            ctrl_q   <= ctrl_d;
            dcc_q    <= dcc_d;
            div3_q   <= div3_d;
        end
    end

    // ---------------- dividers ----------------
    logic       in_prev_q;
    logic       o21_prev_q;
    logic       restart2;
    logic       force_on;
    logic       out2_q, out2_d;
    logic       dcc_on_q;

    lcd_div_if d21 ();
    lcd_div_if d22 ();
    lcd_div_if d31 ();

    assign restart2 = sync_in && !ctrl_q[F_NOSYNC];
    assign force_on = ctrl_q[F_NOSYNC] && ctrl_q[F_FORCE];

    assign d21.in_tick  = div_in && !in_prev_q;
    assign d21.in_lvl   = div_in;
    assign d21.restart  = restart2;
    assign d21.bypass   = ctrl_q[F_BYP21];
    assign d21.start_hi = ctrl_q[F_START21];
    assign d21.phase    = phase_q[F_PH21_LSB +: CNT_W];
    assign d21.low_n    = first_q[F_LOW_LSB +: CNT_W];
    assign d21.high_n   = first_q[F_HIGH_LSB +: CNT_W];

    // second stage counts rising edges of the first stage output
    assign d22.in_tick  = d21.out && !o21_prev_q;
    assign d22.in_lvl   = d21.out;
    assign d22.restart  = restart2;
    assign d22.bypass   = ctrl_q[F_BYP22];
    assign d22.start_hi = ctrl_q[F_START22];
    assign d22.phase    = phase_q[F_PH22_LSB +: CNT_W];
    assign d22.low_n    = second_q[F_LOW_LSB +: CNT_W];
    assign d22.high_n   = second_q[F_HIGH_LSB +: CNT_W];

    // channel 3 first stage: its other controls are outside this block
    assign d31.in_tick  = div_in && !in_prev_q;
    assign d31.in_lvl   = div_in;
    assign d31.restart  = sync_in;
    assign d31.bypass   = 1'b0;
    assign d31.start_hi = 1'b0;
    assign d31.phase    = '0;
    assign d31.low_n    = div3_q[F_LOW_LSB +: CNT_W];
    assign d31.high_n   = div3_q[F_HIGH_LSB +: CNT_W];

    lcd_subdiv u_div21 (.clk(clk), .rst(rst), .dif(d21.div));
    lcd_subdiv u_div22 (.clk(clk), .rst(rst), .dif(d22.div));
    lcd_subdiv u_div31 (.clk(clk), .rst(rst), .dif(d31.div));

    always_comb begin
        out2_d = force_on ? 1'b1 : d22.out;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            in_prev_q  <= 1'b0;
            o21_prev_q <= 1'b0;
            out2_q     <= 1'b0;
            dcc_on_q   <= 1'b1;
        end else begin
            in_prev_q  <= div_in;
            o21_prev_q <= d21.out;
            out2_q     <= out2_d;
            dcc_on_q   <= !dcc_q;
        end
    end

    assign div2_out           = out2_q;
    assign div3_1_out         = d31.out;
    assign duty_correction_on = dcc_on_q;

    // ---------------- AXI4-Lite read path ----------------
    logic              rvalid_q, rvalid_d;
    logic [7:0]        rdata_q,  rdata_d;
    logic [1:0]        rresp_q,  rresp_d;
    logic [10:0]       rd_dec;
    logic [7:0]        rd_val;

    assign s_axi_arready = !rvalid_q;
    assign rd_dec        = lcd_decode(s_axi_araddr);

    always_comb begin
        case (rd_dec[9:0])
            IDX_DIV2_FIRST:  rd_val = first_q;
            IDX_DIV2_PHASE:  rd_val = phase_q;
            IDX_DIV2_SECOND: rd_val = second_q;
            IDX_DIV2_CTRL:   rd_val = {2'h0, ctrl_q};
            IDX_DIV2_DCC:    rd_val = {7'h00, dcc_q};
            IDX_DIV3_FIRST:  rd_val = div3_q;
            IDX_STATUS:      rd_val = {2'h0, d31.running, d22.running, d21.running,
                                       d31.out, out2_q, d21.out};
            default:         rd_val = 8'h00;
        endcase
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rdata_d  = rd_dec[10] ? rd_val : 8'h00;
            rresp_d  = rd_dec[10] ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 8'h00;
            rresp_q  <= RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = {24'h000000, rdata_q};
    assign s_axi_rresp  = rresp_q;

    // ---------------- checks ----------------
    a_sync_ignored: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q[F_NOSYNC] && sync_in && d21.running && !d21.bypass) |=> d21.running)
        else $error("sync acted while ignored");
    a_force_high: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q[F_NOSYNC] && ctrl_q[F_FORCE]) [*2] |-> div2_out)
        else $error("forced output not high");
    a_dcc_follow: assert property (@(posedge clk) disable iff (rst)
        (reg_we && wr_dec[9:0] == IDX_DIV2_DCC) |=> ##1
            (duty_correction_on == !$past(w_data_q[F_DCC_OFF], 2)))
        else $error("duty correction does not follow its control bit");
    a_chain_tick: assert property (@(posedge clk) disable iff (rst)
        (d22.running && !d22.bypass && !d22.restart && !(d21.out && !$past(d21.out)))
        ##1 !d22.bypass |=> $stable(d22.out))
        else $error("second stage moved without first stage rising edge");
    a_write_resp: assert property (@(posedge clk) disable iff (rst)
        wr_go |=> s_axi_bvalid)
        else $error("write response missing");

endmodule : lcd_channel_divider

// [tb/lcd_channel_divider_tb.sv]
// self-checking bench for the channel divider: registers, dividers, sync, force
// assumes the design checks its own assertions; div_in is a 4-cycle square wave
`timescale 1ns/1ps
module lcd_channel_divider_tb;
    import lcd_pkg::*;
    localparam int     P = 4;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              div_in = 1'b0;
    logic              sync_in = 1'b0;
    logic              div2_out;
    logic              div3_1_out;
    logic              duty_correction_on;
    logic [ADDR_W-1:0] s_axi_awaddr = '0;
    logic              s_axi_awvalid = 1'b0;
    logic              s_axi_awready;
    logic [DATA_W-1:0] s_axi_wdata = '0;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic              s_axi_wvalid = 1'b0;
    logic              s_axi_wready;
    logic [1:0]        s_axi_bresp;
    logic              s_axi_bvalid;
    logic              s_axi_bready = 1'b0;
    logic [ADDR_W-1:0] s_axi_araddr = '0;
    logic              s_axi_arvalid = 1'b0;
    logic              s_axi_arready;
    logic [DATA_W-1:0] s_axi_rdata;
    logic [1:0]        s_axi_rresp;
    logic              s_axi_rvalid;
    logic              s_axi_rready = 1'b0;
    logic [1:0]        ph = 2'h0;
    int                n_fail = 0;
    int                n_tests = 0;
    integer            seed = 51;
    logic [7:0]        hold_ctl [6] = '{8'h00, 8'h02, 8'h20, 8'h21, 8'h0c, 8'h04};
    logic [31:0]       hold_lvl [6] = '{0, 1, 0, 1, 1, 0};

    always #50 clk = ~clk;

    always @(posedge clk) begin
        ph     <= ph + 2'h1;
        div_in <= ph[1];
    end

    lcd_channel_divider u_lcd_channel_divider (
        .clk(clk), .rst(rst), .div_in(div_in), .sync_in(sync_in),
        .div2_out(div2_out), .div3_1_out(div3_1_out),
        .duty_correction_on(duty_correction_on),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );

    task automatic end_of_test;
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk32

    task automatic hang(input string nm);
        n_fail++;
        $display("unexpected %s expected done seen timeout", nm);
        end_of_test();
    endtask : hang

    // signals are sampled 1 ns after an edge, i.e. as the next edge will see them
    task automatic axi_wr(input logic [9:0] idx, input logic [1:0] lo, input logic [7:0] d,
                          output logic [1:0] r);
        int   n;
        logic aw_t;
        logic w_t;
        logic b_t;
        @(posedge clk);
        s_axi_awaddr  <= {idx, lo};
        s_axi_wdata   <= {24'($random(seed)), d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            #1;
            aw_t = s_axi_awvalid & s_axi_awready;
            w_t  = s_axi_wvalid & s_axi_wready;
            b_t  = s_axi_bvalid === 1'b1;
            r    = s_axi_bresp;
            @(posedge clk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            if (b_t) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 50) hang("write");
    endtask : axi_wr

    task automatic axi_rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
        int   n;
        logic ar_t;
        logic r_t;
        @(posedge clk);
        s_axi_araddr  <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            #1;
            ar_t = s_axi_arvalid & s_axi_arready;
            r_t  = s_axi_rvalid === 1'b1;
            d    = s_axi_rdata;
            r    = s_axi_rresp;
            @(posedge clk);
            if (ar_t) s_axi_arvalid <= 1'b0;
            if (r_t) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 50) hang("read");
    endtask : axi_rd

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [1:0] r;
        axi_wr(idx, 2'h0, d, r);
        chk32("bresp", RESP_OKAY, r);
    endtask : wr

    task automatic rd_chk(input logic [9:0] idx, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(idx, d, r);
        chk32("rresp", RESP_OKAY, r);
        chk32("rdata", {24'h0, e}, d);
    endtask : rd_chk

    // sync released just after the input phase counter wraps, so restarts line up
    task automatic pulse_sync;
        @(posedge clk);
        sync_in <= 1'b1;
        repeat (3) @(posedge clk);
        do begin
            @(posedge clk);
            #1;
        end while (ph !== 2'h0);
        sync_in <= 1'b0;
    endtask : pulse_sync

    task automatic wait_lvl(input bit s3, input logic v, output int n);
        for (n = 0; n < 3000; n++) begin
            @(posedge clk);
            #1;
            if ((s3 ? div3_1_out : div2_out) === v) break;
        end
        if (n == 3000) hang("output edge");
    endtask : wait_lvl

    task automatic measure(input bit s3, input int lo, input int hi);
        int n;
        wait_lvl(s3, 1'b0, n);
        wait_lvl(s3, 1'b1, n);
        wait_lvl(s3, 1'b0, n);
        chk32("high time", hi, n + 1);
        wait_lvl(s3, 1'b1, n);
        chk32("low time", lo, n + 1);
    endtask : measure

    // clock cycles of one output phase of divider 2 for a given set-up
    function automatic int exp_time(input logic [7:0] ctl, input logic [7:0] c1,
                                    input logic [7:0] c2, input bit lo);
        int t1;
        int t2;
        t1 = ctl[F_BYP21] ? 1 : (c1[7:4] + c1[3:0] + 2);
        t2 = (lo ? c2[7:4] : c2[3:0]) + 1;
        if (ctl[F_BYP21] && ctl[F_BYP22]) return P / 2;
        if (ctl[F_BYP22]) return ((lo ? c1[7:4] : c1[3:0]) + 1) * P;
        return t1 * t2 * P;
    endfunction : exp_time

    initial begin
        logic [7:0]  v;
        logic [7:0]  u;
        logic [7:0]  c;
        logic [9:0]  idx;
        logic [31:0] d;
        logic [1:0]  r;
        int          n0;
        int          n1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk32("dcc flag", 1, duty_correction_on);
        for (int i = 0; i < 6; i++) rd_chk(IDX_DIV2_FIRST + 10'(i), 8'h00);
        for (int i = 0; i < 24; i++) begin
            idx = IDX_DIV2_FIRST + 10'($unsigned($random(seed)) % 6);
            v   = 8'($random(seed));
            if (idx == IDX_DIV2_DCC) v[7:1] = 7'h0;
            wr(idx, v);
            rd_chk(idx, idx == IDX_DIV2_CTRL ? v & 8'h3f : v);
        end
        axi_wr(10'h1a0, 2'h0, 8'h5a, r);
        chk32("bresp", RESP_SLVERR, r);
        axi_wr(IDX_DIV2_FIRST, 2'h1, 8'h5a, r);
        chk32("bresp", RESP_SLVERR, r);
        axi_rd(10'h1a0, d, r);
        chk32("rresp", RESP_SLVERR, r);
        chk32("rdata", 0, d);
        wr(IDX_DIV2_CTRL, 8'h00);
        wr(IDX_DIV2_PHASE, 8'h00);
        // write with byte lane 0 off must leave the register alone
        s_axi_wstrb <= 4'he;
        wr(IDX_DIV2_PHASE, 8'h5a);
        s_axi_wstrb <= 4'hf;
        rd_chk(IDX_DIV2_PHASE, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            wr(IDX_DIV3_FIRST, v);
            pulse_sync();
            measure(1'b1, (v[7:4] + 1) * P, (v[3:0] + 1) * P);
        end
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed)) & 8'h33;
            u = 8'($random(seed)) & 8'h33;
            c = {2'h0, 2'(i), 4'h0};
            wr(IDX_DIV2_FIRST, v);
            wr(IDX_DIV2_SECOND, u);
            wr(IDX_DIV2_CTRL, c);
            pulse_sync();
            measure(1'b0, exp_time(c, v, u, 1'b1), exp_time(c, v, u, 1'b0));
        end
        wr(IDX_DIV2_CTRL, 8'h20);
        wr(IDX_DIV2_FIRST, 8'h00);
        pulse_sync();
        wait_lvl(1'b0, 1'b1, n0);
        for (int i = 0; i < 3; i++) begin
            v = {4'($random(seed)), 4'(1 + $unsigned($random(seed)) % 15)};
            wr(IDX_DIV2_PHASE, v);
            pulse_sync();
            wait_lvl(1'b0, 1'b1, n1);
            chk32("phase delay", v[3:0] * P, n1 - n0);
        end
        wr(IDX_DIV2_PHASE, 8'h00);
        @(posedge clk);
        sync_in <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wr(IDX_DIV2_CTRL, hold_ctl[i]);
            repeat (6) @(posedge clk);
            #1;
            chk32("held level", hold_lvl[i], div2_out);
        end
        // sync still high: channel 2 dividers must run only because it is ignored
        wr(IDX_DIV2_CTRL, 8'h08);
        measure(1'b0, exp_time(8'h08, 8'h00, u, 1'b1), exp_time(8'h08, 8'h00, u, 1'b0));
        @(posedge clk);
        sync_in <= 1'b0;
        wr(IDX_DIV2_DCC, 8'h01);
        repeat (3) @(posedge clk);
        #1;
        chk32("dcc flag", 0, duty_correction_on);
        wr(IDX_DIV2_DCC, 8'h00);
        repeat (3) @(posedge clk);
        #1;
        chk32("dcc flag", 1, duty_correction_on);
        end_of_test();
    end
endmodule : lcd_channel_divider_tb
